// ### hdl/twrp_master.sv
// Two-wire register port, controller end issuing single-byte transfers
`timescale 1ns/1ps
module twrp_master
  import twrp_pkg::*;
#(
  parameter int QUARTER = TWRP_QUARTER_CYC  // core_clk cycles per quarter link period
) (
  input  wire logic        core_clk, // 250 MHz clock
  input  wire logic        rst,      // Async reset, active high
  twrp_if.master           bus,      // Two-wire link
  input  wire logic        reqValid, // Request present
  output logic             reqReady, // Request taken when high with reqValid
  input  wire logic        reqRead,  // 1 read, 0 write
  input  wire logic        reqSel,   // Target select bit
  input  wire logic [7:0]  reqPtr,   // Register address
  input  wire logic [7:0]  reqData,  // Write data
  output logic             done,     // Transfer finished, one cycle
  output logic             ackErr,   // Target did not acknowledge
  output logic [7:0]       rdData    // Read result
);
  import twrp_pkg::*;

  if (QUARTER < 2 || QUARTER > 255) begin : gBadQuarter
    $error("QUARTER out of range");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    twrp_mstate_t st;
    logic [1:0]   q;
    logic [7:0]   div;
    logic [3:0]   idx;
    logic [2:0]   step;
    logic [7:0]   sh;
    logic         rd;
    logic         sel;
    logic [7:0]   ptr;
    logic [7:0]   wd;
    logic         sclOe;
    logic         sdaOe;
    logic         done;
    logic         ackErr;
    logic [7:0]   rdData;
    logic [1:0]   sdaSy;
  } twrp_mst_t;

  twrp_mst_t s_reg;
  twrp_mst_t s_next;

  function automatic twrp_step_t stepKind(input logic rd, input logic [2:0] n);
    twrp_step_t k;
    k = K_STOP;
    case (n)
      3'd0:    k = K_ADDRW;
      3'd1:    k = K_PTR;
      3'd2:    k = rd ? K_RESTART : K_DATA;
      3'd3:    k = rd ? K_ADDRR : K_STOP;
      3'd4:    k = rd ? K_RX : K_STOP;
      default: k = K_STOP;
    endcase
    stepKind = k;
  endfunction

  function automatic logic [7:0] stepByte(input twrp_mst_t m, input twrp_step_t k);
    case (k)
      K_ADDRW: stepByte = {TWRP_ADDR_HI, m.sel, 1'b0};
      K_ADDRR: stepByte = {TWRP_ADDR_HI, m.sel, 1'b1};
      K_PTR:   stepByte = m.ptr;
      K_DATA:  stepByte = m.wd;
      default: stepByte = 8'h00;
    endcase
  endfunction

  twrp_step_t kind;
  twrp_step_t nextKind;
  logic       tick;
  logic       isRx;

  assign kind     = stepKind(s_reg.rd, s_reg.step);
  assign nextKind = stepKind(s_reg.rd, 3'(s_reg.step + 3'd1));
  assign tick     = (s_reg.div == 8'(QUARTER - 1));
  assign isRx     = (kind == K_RX);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next       = s_reg;
    s_next.done  = 1'b0;
    s_next.sdaSy = {s_reg.sdaSy[0], bus.sda};
    s_next.div   = (s_reg.st == M_IDLE || tick) ? 8'h00 : 8'(s_reg.div + 8'h01);
    case (s_reg.st)
      M_IDLE: begin
        if (reqValid) begin
          s_next.rd     = reqRead;
          s_next.sel    = reqSel;
          s_next.ptr    = reqPtr;
          s_next.wd     = reqData;
          s_next.step   = 3'd0;
          s_next.q      = 2'd0;
          s_next.ackErr = 1'b0;
          s_next.st     = M_START;
        end
      end
      M_START: begin
        if (tick) begin
          s_next.q = 2'(s_reg.q + 2'd1);
          case (s_reg.q)
            2'd0: s_next.sdaOe = 1'b0;
            2'd1: s_next.sclOe = 1'b0;
            2'd2: s_next.sdaOe = 1'b1;
            default: begin
              s_next.sclOe = 1'b1;
              s_next.idx   = 4'd0;
              s_next.sh    = stepByte(s_reg, nextKind);
              s_next.step  = (s_reg.step == 3'd0) ? 3'd0 : 3'(s_reg.step + 3'd1);
              s_next.sh    = stepByte(s_reg, (s_reg.step == 3'd0) ? K_ADDRW : nextKind);
              s_next.st    = M_BYTE;
            end
          endcase
        end
      end
      M_BYTE: begin
        if (tick) begin
          s_next.q = 2'(s_reg.q + 2'd1);
          case (s_reg.q)
            2'd0: s_next.sdaOe = !isRx && s_reg.idx < 4'd8 && !s_reg.sh[7];
            2'd1: s_next.sclOe = 1'b0;
            2'd2: begin
              if (isRx && s_reg.idx < 4'd8) begin
                s_next.sh = {s_reg.sh[6:0], s_reg.sdaSy[1]};
              end else if (!isRx && s_reg.idx == 4'd8 && s_reg.sdaSy[1]) begin
                s_next.ackErr = 1'b1;
              end
            end
            default: begin
              // Data is left alone here; it moves only once the clock is low
              s_next.sclOe = 1'b1;
              s_next.idx   = 4'(s_reg.idx + 4'd1);
              if (!isRx && s_reg.idx < 4'd8) begin
                s_next.sh = {s_reg.sh[6:0], 1'b0};
              end
              if (s_reg.idx == 4'd8) begin
                // Single-byte read ends with no acknowledge from us
                s_next.idx = 4'd0;
                if (isRx) begin
                  s_next.rdData = s_reg.sh;
                end
                if (s_next.ackErr || nextKind == K_STOP) begin
                  s_next.st = M_STOP;
                end else if (nextKind == K_RESTART) begin
                  s_next.step = 3'(s_reg.step + 3'd1);
                  s_next.st   = M_START;
                end else begin
                  s_next.step = 3'(s_reg.step + 3'd1);
                  s_next.sh   = stepByte(s_reg, nextKind);
                end
              end
            end
          endcase
        end
      end
      default: begin
        if (tick) begin
          s_next.q = 2'(s_reg.q + 2'd1);
          case (s_reg.q)
            2'd0: s_next.sdaOe = 1'b1;
            2'd1: s_next.sclOe = 1'b0;
            2'd2: s_next.sdaOe = 1'b0;
            default: begin
              s_next.done = 1'b1;
              s_next.st   = M_IDLE;
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_reg <= '{st: M_IDLE, q: 2'd0, div: 8'h00, idx: 4'd0, step: 3'd0, sh: 8'h00,
                 rd: 1'b0, sel: 1'b0, ptr: 8'h00, wd: 8'h00, sclOe: 1'b0, sdaOe: 1'b0,
                 done: 1'b0, ackErr: 1'b0, rdData: 8'h00, sdaSy: 2'h3};
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign bus.mSclOe = s_reg.sclOe;
  assign bus.mSdaOe = s_reg.sdaOe;
  assign reqReady   = (s_reg.st == M_IDLE);
  assign done       = s_reg.done;
  assign ackErr     = s_reg.ackErr;
  assign rdData     = s_reg.rdData;
endmodule

// ### shared/twrp_pkg.sv
// Shared constants and types for the two-wire register port
package twrp_pkg;
  // ----------------------------------------------------------------
  // Addressing
  // ----------------------------------------------------------------
  localparam logic [5:0] TWRP_ADDR_HI   = 6'h26;  // Upper six target address bits 100110
  localparam logic [7:0] TWRP_TOP_REG   = 8'h44;  // Highest register address
  localparam logic [7:0] TWRP_REV_REG   = 8'h00;  // Read-only revision register
  localparam int         TWRP_NREG      = 69;     // Registers 0x00 to 0x44
  localparam logic [7:0] TWRP_REG_RST   = 8'h00;  // Reset value of writable registers
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int TWRP_CLK_PERIOD_NS = 4;   // core_clk period
  localparam int TWRP_SCL_PERIOD_NS = 80;  // Generated link clock period
  localparam int TWRP_QUARTER_CYC   = TWRP_SCL_PERIOD_NS / (4 * TWRP_CLK_PERIOD_NS);
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [TWRP_NREG-1:0][7:0] twrp_regs_t;
  typedef enum logic [2:0] {T_IDLE, T_ADDR, T_PTR, T_DATA, T_ACK, T_TX, T_MACK, T_WAIT}
    twrp_tstate_t;
  typedef enum logic [2:0] {M_IDLE, M_START, M_BYTE, M_STOP} twrp_mstate_t;
  typedef enum logic [2:0] {K_ADDRW, K_PTR, K_DATA, K_RESTART, K_ADDRR, K_RX, K_STOP}
    twrp_step_t;
endpackage

// ### shared/twrp_if.sv
// Two-wire link between controller and target, open-drain wiring
`timescale 1ns/1ps
interface twrp_if;
  logic mSclOe;  // Controller pulls clock low
  logic mSdaOe;  // Controller pulls data low
  logic tSdaOe;  // Target pulls data low
  logic scl;     // Resolved clock level
  logic sda;     // Resolved data level

  // Pull-ups: a line is high unless someone pulls it low
  assign scl = ~mSclOe;
  assign sda = ~(mSdaOe | tSdaOe);

  modport target (input scl, input sda, output tSdaOe);
  modport master (input scl, input sda, output mSclOe, output mSdaOe);
endinterface

// ### hdl/twrp_target.sv
// Two-wire register port, target end with register file
//
// Summary of operation
// - Acts only as bus target, never controller.
// - Data changes only while clock is low.
// - Data edge during high clock is start/stop.
// - Falling data with clock high is start.
// - First byte: 7-bit address, then direction.
// - Own address acknowledged low on ninth pulse.
// - Address 100110 plus one select bit.
// - Every byte moves most significant bit first.
// - Unacknowledged write leaves data line released.
// - Controller not acknowledging ends read output.
// - Write: byte after address sets pointer.
// - Pointer advances after each written data byte.
// - Pointer clamps at 0x44; higher base refused.
// - Controller writes pointer first, then reads.
// - Reads start at last set pointer.
// - Pointer advances after each byte the controller acknowledges.
// - Stop returns the port to idle.
// - Repeated start restarts address decoding.
// - Register 0x00 is read-only revision.
`timescale 1ns/1ps
module twrp_target
  import twrp_pkg::*;
#(
  parameter logic [7:0] REV_ID = 8'h5A  // Revision value, arbitrary
) (
  input  wire logic               core_clk, // 250 MHz clock
  input  wire logic               rst,      // Async reset, active high
  twrp_if.target                  bus,      // Two-wire link
  input  wire logic               devSel,   // Lowest address bit, static tie
  output logic                    wrStb,    // Register written, one cycle
  output logic [7:0]              wrAddr,   // Address of written register
  output logic [7:0]              wrData,   // Value written
  output twrp_pkg::twrp_regs_t    cfgRegs,  // Whole register file
  output logic                    busy      // Port addressed and active
);
  import twrp_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    twrp_tstate_t st;
    twrp_tstate_t nxt;
    logic [3:0]   cnt;
    logic [7:0]   sh;
    logic [7:0]   ptr;
    logic         sdaDrv;
    logic         wrStb;
    logic [7:0]   wrAddr;
    logic [7:0]   wrData;
    twrp_regs_t   regs;
    logic [2:0]   sclSy;
    logic [2:0]   sdaSy;
  } twrp_tgt_t;

  twrp_tgt_t s_reg;
  twrp_tgt_t s_next;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] incPtr(input logic [7:0] p);
    incPtr = (p >= TWRP_TOP_REG) ? TWRP_TOP_REG : 8'(p + 8'h01);
  endfunction

  function automatic logic [7:0] rdReg(input twrp_regs_t r, input logic [7:0] p);
    rdReg = (p == TWRP_REV_REG) ? REV_ID : r[p[6:0]];
  endfunction

  logic sclNow;
  logic sclOld;
  logic sdaNow;
  logic sdaOld;
  logic sclRise;
  logic sclFall;
  logic startDet;
  logic stopDet;
  logic [7:0] rxByte;
  logic [7:0] rdNow;

  // Only the second and third stages are looked at
  assign sclNow   = s_reg.sclSy[1];
  assign sclOld   = s_reg.sclSy[2];
  assign sdaNow   = s_reg.sdaSy[1];
  assign sdaOld   = s_reg.sdaSy[2];
  assign sclRise  = sclNow & ~sclOld;
  assign sclFall  = ~sclNow & sclOld;
  assign startDet = sclNow & sclOld & sdaOld & ~sdaNow;
  assign stopDet  = sclNow & sclOld & ~sdaOld & sdaNow;
  assign rxByte   = s_reg.sh;
  assign rdNow    = rdReg(s_reg.regs, s_reg.ptr);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next       = s_reg;
    s_next.wrStb = 1'b0;
    s_next.sclSy = {s_reg.sclSy[1:0], bus.scl};
    s_next.sdaSy = {s_reg.sdaSy[1:0], bus.sda};

    if (startDet) begin
      // Start or repeated start: decode a fresh address, nothing stored
      s_next.st     = T_ADDR;
      s_next.cnt    = 4'd0;
      s_next.sdaDrv = 1'b0;
    end else if (stopDet) begin
      s_next.st     = T_IDLE;
      s_next.sdaDrv = 1'b0;
    end else begin
      case (s_reg.st)
        T_ADDR, T_PTR, T_DATA: begin
          if (sclRise && s_reg.cnt < 4'd8) begin
            s_next.sh  = {s_reg.sh[6:0], sdaNow};
            s_next.cnt = 4'(s_reg.cnt + 4'd1);
          end else if (sclFall && s_reg.cnt == 4'd8) begin
            s_next.st = T_ACK;
            if (s_reg.st == T_ADDR) begin
              if (rxByte[7:1] == {TWRP_ADDR_HI, devSel}) begin
                s_next.sdaDrv = 1'b1;
                s_next.nxt    = rxByte[0] ? T_TX : T_PTR;
              end else begin
                s_next.st = T_WAIT;
              end
            end else if (s_reg.st == T_PTR) begin
              if (rxByte <= TWRP_TOP_REG) begin
                s_next.ptr    = rxByte;
                s_next.sdaDrv = 1'b1;
                s_next.nxt    = T_DATA;
              end else begin
                s_next.st = T_WAIT;
              end
            end else begin
              if (s_reg.ptr != TWRP_REV_REG) begin
                s_next.regs[s_reg.ptr[6:0]] = rxByte;
              end
              s_next.wrStb  = 1'b1;
              s_next.wrAddr = s_reg.ptr;
              s_next.wrData = rxByte;
              s_next.ptr    = incPtr(s_reg.ptr);
              s_next.sdaDrv = 1'b1;
              s_next.nxt    = T_DATA;
            end
          end
        end
        T_ACK: begin
          // Acknowledge is held through the ninth pulse; on its fall it is released, or the first read bit goes out
          if (sclFall) begin
            s_next.cnt = 4'd0;
            s_next.st  = s_reg.nxt;
            if (s_reg.nxt == T_TX) begin
              s_next.sh     = rdNow;
              s_next.sdaDrv = ~rdNow[7];
            end else begin
              s_next.sdaDrv = 1'b0;
            end
          end
        end
        T_TX: begin
          if (sclRise) begin
            s_next.cnt = 4'(s_reg.cnt + 4'd1);
          end else if (sclFall) begin
            if (s_reg.cnt < 4'd8) begin
              s_next.sdaDrv = ~s_reg.sh[3'(4'd7 - s_reg.cnt)];
            end else begin
              s_next.sdaDrv = 1'b0;
              s_next.st     = T_MACK;
            end
          end
        end
        T_MACK: begin
          if (sclRise) begin
            if (!sdaNow) begin
              s_next.ptr = incPtr(s_reg.ptr);
              s_next.sh  = rdReg(s_reg.regs, incPtr(s_reg.ptr));
              s_next.cnt = 4'd0;
              s_next.nxt = T_TX;
              s_next.st  = T_ACK;
            end else begin
              s_next.st = T_WAIT;
            end
          end
        end
        default: begin
          // Idle or ignoring the bus until the next start or stop
          s_next.sdaDrv = 1'b0;
        end
      endcase
    end
  end

  // Controller acknowledged: next byte's first bit leaves on the ninth fall.
  // T_ACK reused for that fall with nothing driven during the ninth pulse.

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_reg.st     <= T_IDLE;
      s_reg.nxt    <= T_IDLE;
      s_reg.cnt    <= 4'd0;
      s_reg.sh     <= 8'h00;
      s_reg.ptr    <= 8'h00;
      s_reg.sdaDrv <= 1'b0;
      s_reg.wrStb  <= 1'b0;
      s_reg.wrAddr <= 8'h00;
      s_reg.wrData <= 8'h00;
      s_reg.regs   <= {TWRP_NREG{TWRP_REG_RST}};
      s_reg.sclSy  <= 3'h7;
      s_reg.sdaSy  <= 3'h7;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    cfgRegs    = s_reg.regs;
    cfgRegs[0] = REV_ID;
  end

  assign bus.tSdaOe = s_reg.sdaDrv;
  assign wrStb      = s_reg.wrStb;
  assign wrAddr     = s_reg.wrAddr;
  assign wrData     = s_reg.wrData;
  assign busy       = (s_reg.st != T_IDLE) && (s_reg.st != T_WAIT) && (s_reg.st != T_ADDR);
endmodule

// ### testbench/twrp_assertions.sv
// Concurrent checks on the link between controller end and target end
`timescale 1ns/1ps
module twrp_assertions (
  input wire logic core_clk, // Link-side clock
  input wire logic rst,      // Async reset, active high
  input wire logic mSclOe,   // Controller clock pull
  input wire logic mSdaOe,   // Controller data pull
  input wire logic tSdaOe,   // Target data pull
  input wire logic scl,      // Resolved clock
  input wire logic sda       // Resolved data
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Clock rises since the last start or stop
  // ----------------------------------------------------------------
  logic       sclQ_reg;
  logic       sdaQ_reg;
  logic [4:0] riseCnt_reg;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sclQ_reg <= 1'b1;
      sdaQ_reg <= 1'b1;
      riseCnt_reg <= 5'h00;
    end else begin
      sclQ_reg <= scl;
      sdaQ_reg <= sda;
      if (scl && sclQ_reg && (sda != sdaQ_reg)) begin
        riseCnt_reg <= 5'h00;
      end else if (scl && !sclQ_reg && riseCnt_reg != 5'h1F) begin
        riseCnt_reg <= riseCnt_reg + 5'h01;
      end
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  chk_tgt_data_stable: assert property (scl && $past(scl) |-> $stable(tSdaOe))
    else $error("target data changed while clock high");
  chk_tgt_edge_late: assert property ($changed(tSdaOe) |-> !scl &&
    ($past(scl, 2) || $past(scl, 3) || $past(scl, 4) || $past(scl, 5)))
    else $error("target data changed away from a clock fall");
  chk_start_quiet: assert property (scl && $past(scl) && $fell(sda) |-> !tSdaOe [*8])
    else $error("target drove data around a start");
  chk_stop_idle: assert property (scl && $past(scl) && $rose(sda) |-> !tSdaOe [*8])
    else $error("target drove data after a stop");
  chk_ack_hold: assert property ($rose(tSdaOe) |-> tSdaOe [*8])
    else $error("target pull too short");
  chk_addr_ack: assert property ($rose(tSdaOe) && riseCnt_reg < 5'h09 |-> riseCnt_reg == 5'h08)
    else $error("address acknowledge not after eighth bit");
  chk_mst_start: assert property ($rose(mSdaOe) && scl |-> scl [*4])
    else $error("controller start without clock high");
  chk_mst_stop: assert property ($fell(mSdaOe) && scl |-> (scl && sda) [*4])
    else $error("bus not idle after stop");
endmodule

// ### testbench/two_wire_register_port_tb.sv
// Self-checking bench: controller end against target end, plus bit-level driver
`timescale 1ns/1ps
module two_wire_register_port_tb;
  import twrp_pkg::*;
  localparam logic [7:0] REV = 8'hA7;  // Revision value, arbitrary
  logic       core_clk, rst, reqValid, reqRead, reqSel, reqReady, done, ackErr, wrStbB, ack;
  logic [7:0] reqPtr, reqData, rdData, rx, p, d;
  logic       busyB;
  logic [7:0] wrAddrB, wrDataB;
  int         expWr [$];
  logic [7:0] mdl [TWRP_NREG];
  logic [7:0] mdlB [TWRP_NREG];
  logic [7:0] tp [5] = '{8'h00, 8'h00, 8'h44, 8'h44, 8'h45};
  twrp_regs_t regsA, regsB;
  int         miscompares = 0, checks = 0, wrCntB = 0, seed = 32'h184AE083, i, r;
  twrp_if lk();
  twrp_if bb();
  twrp_master u_twrp_master (.core_clk(core_clk), .rst(rst), .bus(lk), .reqValid(reqValid),
    .reqReady(reqReady), .reqRead(reqRead), .reqSel(reqSel), .reqPtr(reqPtr),
    .reqData(reqData), .done(done), .ackErr(ackErr), .rdData(rdData));
  twrp_target #(.REV_ID(REV)) u_twrp_target (.core_clk(core_clk), .rst(rst), .bus(lk),
    .devSel(1'b0), .wrStb(), .wrAddr(), .wrData(), .cfgRegs(regsA), .busy());
  twrp_target #(.REV_ID(REV)) u_twrp_target_b (.core_clk(core_clk), .rst(rst), .bus(bb),
    .devSel(1'b1), .wrStb(wrStbB), .wrAddr(wrAddrB), .wrData(wrDataB), .cfgRegs(regsB),
    .busy(busyB));
  twrp_assertions u_twrp_assertions (.core_clk(core_clk), .rst(rst), .mSclOe(lk.mSclOe),
    .mSdaOe(lk.mSdaOe), .tSdaOe(lk.tSdaOe), .scl(lk.scl), .sda(lk.sda));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic mreq(input logic rd, input logic sel, input logic [7:0] a, input logic [7:0] dt);
    int  n;
    logic ok;
    @(posedge core_clk);
    reqValid <= 1'b1;
    reqRead <= rd;
    reqSel <= sel;
    reqPtr <= a;
    reqData <= dt;
    #1;
    while (reqReady !== 1'b1) begin
      @(posedge core_clk);
      #1;
    end
    @(posedge core_clk);
    reqValid <= 1'b0;
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (done !== 1'b1 && n < 8000);
    chk(8'(done), 8'h01);
    ok = !sel && a <= TWRP_TOP_REG;
    chk(ackErr, !ok);
    if (ok && !rd && a != TWRP_REV_REG) mdl[a] = dt;
    if (ok && rd) chk(rdData, mdl[a]);
    if (a <= TWRP_TOP_REG) chk(regsA[a], mdl[a]);
  endtask
  task automatic w5;
    repeat (5) @(posedge core_clk);
  endtask
  task automatic bstart;
    @(posedge core_clk);
    bb.mSdaOe <= 1'b0;
    w5;
    bb.mSclOe <= 1'b0;
    w5;
    bb.mSdaOe <= 1'b1;
    w5;
    bb.mSclOe <= 1'b1;
    w5;
  endtask
  task automatic bstop;
    bb.mSdaOe <= 1'b1;
    w5;
    bb.mSclOe <= 1'b0;
    w5;
    bb.mSdaOe <= 1'b0;
    w5;
  endtask
  // One bit per 80 ns: clock low 10 cycles, high 10 cycles
  task automatic bbit(input logic b, output logic s);
    bb.mSdaOe <= ~b;
    w5;
    bb.mSclOe <= 1'b0;
    w5;
    w5;
    s = bb.sda;
    bb.mSclOe <= 1'b1;
    w5;
  endtask
  task automatic bbyte(input logic [7:0] tx, input logic ackIn);
    logic [8:0] q;
    logic       s;
    for (int k = 0; k < 9; k++) begin
      bbit((k < 8) ? tx[7-k] : ackIn, s);
      q = {q[7:0], s};
    end
    rx = q[8:1];
    ack = !q[0];
  endtask
  task automatic bhead(input logic [7:0] a);
    bstart;
    bbyte({TWRP_ADDR_HI, 2'b10}, 1'b1);
    chk(ack, 1'b1);
    bbyte(a, 1'b1);
  endtask
  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (wrStbB === 1'b1) begin
      wrCntB++;
      if (expWr.size() > 0) begin
        chk(wrAddrB, expWr[0][15:8]);
        chk(wrDataB, expWr[0][7:0]);
        void'(expWr.pop_front());
      end
    end
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    miscompares++;
    report_and_stop;
  end
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    rst = 1'b1;
    {reqValid, reqRead, reqSel, reqPtr, reqData} = '0;
    bb.mSclOe = 1'b0;
    bb.mSdaOe = 1'b0;
    for (i = 0; i < TWRP_NREG; i++) begin
      mdl[i] = TWRP_REG_RST;
      mdlB[i] = TWRP_REG_RST;
    end
    mdl[0] = REV;
    mdlB[0] = REV;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    for (i = 0; i < TWRP_NREG; i++) chk(regsA[i], mdl[i]);
    for (i = 0; i < 29; i++) begin
      r = $random(seed);
      p = (i < 5) ? tp[i] : 8'(r[15:8] % 72);
      mreq((i < 5) ? i[0] : r[0], (i < 5) ? 1'b0 : r[3:1] == 3'h0, p, r[23:16]);
    end
    // Burst write past the top register, then burst read with repeated start
    bhead(8'h43);
    chk(ack, 1'b1);
    chk(8'(busyB), 8'h01);
    p = 8'h43;
    for (i = 0; i < 3; i++) begin
      d = 8'($random(seed));
      mdlB[p] = d;
      expWr.push_back(int'({p, d}));
      p = (p < TWRP_TOP_REG) ? p + 8'h01 : p;
      bbyte(d, 1'b1);
      chk(ack, 1'b1);
    end
    bstop;
    chk(8'(busyB), 8'h00);
    chk(regsB[8'h43], mdlB[8'h43]);
    chk(regsB[8'h44], mdlB[8'h44]);
    bhead(8'h43);
    bstart;
    bbyte({TWRP_ADDR_HI, 2'b11}, 1'b1);
    chk(ack, 1'b1);
    p = 8'h43;
    for (i = 0; i < 3; i++) begin
      bbyte(8'hFF, i == 2);
      chk(rx, mdlB[p]);
      p = (p < TWRP_TOP_REG) ? p + 8'h01 : p;
    end
    chk(bb.tSdaOe, 1'b0);
    bstop;
    // Wrong select bit and out-of-range pointer
    bstart;
    bbyte({TWRP_ADDR_HI, 2'b00}, 1'b1);
    chk(ack, 1'b0);
    chk(8'(busyB), 8'h00);
    bstop;
    bhead(8'h45);
    chk(ack, 1'b0);
    bstop;
    // Start and stop in mid-byte
    bhead(8'h20);
    for (i = 0; i < 3; i++) bbit(i[0], ack);
    bhead(8'h21);
    expWr.push_back(int'({8'h21, 8'h6C}));
    bbyte(8'h6C, 1'b1);
    for (i = 0; i < 4; i++) bbit(1'b1, ack);
    bstop;
    chk(regsB[8'h20], 8'h00);
    chk(regsB[8'h21], 8'h6C);
    chk(regsB[8'h22], 8'h00);
    chk(8'(wrCntB), 8'h04);
    chk(8'(expWr.size()), 8'h00);
    report_and_stop;
  end
endmodule
